// File: rtl/thermal_params.svh
// Function
// - pointer bits 7..2 must be zero; a one there aborts the operation in progress.
// - pointer value is held across bus transactions until rewritten.
// - pointer clears to zero at power-up, selecting the reading register.
// - select 00 reading, 01 settings, 10 lower trip, 11 upper trip.
// - lower trip point resets to 75 degrees, 0x4B00.
// - upper trip point resets to 80 degrees, 0x5000.
// - settings: standby, alarm style, active level, fault count low/high, top bits zero.
// - settings bits 7..5 read-only, others read/write, whole register resets to zero.
// - alarm style zero is comparator, one is interrupt.
// - reading register takes each conversion finished outside a read as two's complement.
// - conversion always loads compare buffer; reading copied only when no read runs.
// - during a read the old reading stays; next unmasked conversion updates it.
// - alarm faults are evaluated on every conversion regardless of bus activity.
// - reading bit 15 is sign, bit 14 top magnitude, nine bits at 15..7.
// - reading bits below the nine-bit value read as zero.
// - reading register clears to zero at power-up.
// - trip points use the same two's complement layout as the reading.
// - only the nine top trip-point bits take part in comparison.
// - fault count 00/01/10/11 needs 1/2/4/6 consecutive faulty conversions.
// - comparator alarm sets after hot run, holds until reading below lower trip.
// - interrupt alarm released by any register read; re-arms after cold run.
// - standby lets conversion finish, halts; clears alarm in interrupt style.
`ifndef THERMAL_PARAMS_SVH
`define THERMAL_PARAMS_SVH

// ----------------------------------------------------------------------
// register select codes
// ----------------------------------------------------------------------
`define SEL_READING 2'h0
`define SEL_SETTINGS 2'h1
`define SEL_LOWER 2'h2
`define SEL_UPPER 2'h3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SELECT_RESET 2'h0
`define SETTINGS_RESET 5'h00
`define READING_RESET 9'h000
`define LOWER_RESET 16'h4B00
`define UPPER_RESET 16'h5000

// ----------------------------------------------------------------------
// settings field positions
// ----------------------------------------------------------------------
`define STANDBY_BIT 0
`define STYLE_BIT 1
`define LEVEL_BIT 2
`define FAULT_LOW_BIT 3
`define FAULT_HIGH_BIT 4
`define SETTINGS_USED 5

// ----------------------------------------------------------------------
// reading layout and fault runs
// ----------------------------------------------------------------------
`define READING_TOP 15
`define READING_BOTTOM 7
`define RUN_1 3'h1
`define RUN_2 3'h2
`define RUN_4 3'h4
`define RUN_6 3'h6

`endif

// File: rtl/thermal_pkg.sv
package thermal_pkg;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef logic [1:0] select_t;
  typedef logic [8:0] reading_t;

  // interrupt-style alarm watches for a hot run, then for a cold run
  typedef enum logic [0:0] {
    HUNT_HOT = 1'b0,
    HUNT_COLD = 1'b1
  } hunt_e;

endpackage : thermal_pkg

// File: rtl/thermal_sensor_register_file.sv
`timescale 1ns/1ps
`include "thermal_params.svh"

module thermal_sensor_register_file (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic selectWrite,
  input wire logic [7:0] selectData,
  input wire logic regWrite,
  input wire logic [15:0] writeData,
  input wire logic readStart,
  input wire logic readActive,
  input wire logic convDone,
  input wire logic [8:0] convResult,
  output logic [15:0] readData,
  output logic [1:0] selectValue,
  output logic abortOp,
  output logic standbyHalt,
  output logic alarmActive,
  output logic alarmPinOut,
  output logic alarmPinOe
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------

  // consecutive faulty conversions needed for a fault count code
  function automatic logic [2:0] run_needed(input logic [1:0] code);
    logic [2:0] need;
    need = `RUN_1;
    unique case (code)
      2'h0: need = `RUN_1;
      2'h1: need = `RUN_2;
      2'h2: need = `RUN_4;
      2'h3: need = `RUN_6;
    endcase
    return need;
  endfunction : run_needed

  // nine-bit signed field of a trip point, low bits ignored
  function automatic thermal_pkg::reading_t trip_field(input logic [15:0] trip);
    return trip[`READING_TOP:`READING_BOTTOM];
  endfunction : trip_field

  // true when the held pointer addresses the given register
  function automatic logic hits(input thermal_pkg::select_t sel, input logic [1:0] code);
    return sel == code;
  endfunction : hits

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  thermal_pkg::select_t select;
  logic [4:0] settings;
  thermal_pkg::reading_t reading;
  thermal_pkg::reading_t compareBuf;
  logic [15:0] lowerTrip;
  logic [15:0] upperTrip;
  logic [2:0] faultRun;
  logic alarm;
  thermal_pkg::hunt_e hunt;
  logic pointerBad;
  logic writeSettings;
  logic standbyRise;
  logic styleIrq;
  logic [2:0] need;
  logic isHot;
  logic isCold;
  logic faulty;
  logic runDone;
  logic [2:0] next_faultRun;
  logic next_alarm;
  thermal_pkg::hunt_e next_hunt;
  logic [15:0] readingWord;
  logic [15:0] next_readData;
  logic evalStrobe;
  logic writeLower;
  logic writeUpper;
  logic releaseReq;

  // ----------------------------------------------------------------------
  // decode of bus strobes
  // ----------------------------------------------------------------------

  // pointer byte with any top bit set is an illegal select
  assign pointerBad = selectWrite && (selectData[7:2] != 6'h00);
  assign writeSettings = regWrite && hits(select, `SEL_SETTINGS);
  assign writeLower = regWrite && hits(select, `SEL_LOWER);
  assign writeUpper = regWrite && hits(select, `SEL_UPPER);
  assign releaseReq = styleIrq && (readStart || standbyRise);
  assign standbyRise = writeSettings && writeData[`STANDBY_BIT] &&
                       !settings[`STANDBY_BIT];
  assign styleIrq = settings[`STYLE_BIT];
  assign need = run_needed(settings[`FAULT_HIGH_BIT:`FAULT_LOW_BIT]);

  // ----------------------------------------------------------------------
  // register select pointer
  // ----------------------------------------------------------------------

  // pointer kept until a legal pointer byte arrives
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      select <= `SELECT_RESET;
    end else if (selectWrite && !pointerBad) begin
      select <= selectData[1:0];
    end
  end

  // abort pulse for an illegal pointer byte
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      abortOp <= 1'b0;
    end else begin
      abortOp <= pointerBad;
    end
  end

  // ----------------------------------------------------------------------
  // settings and trip points
  // ----------------------------------------------------------------------

  // only the five defined bits are stored, top bits stay zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      settings <= `SETTINGS_RESET;
    end else if (writeSettings) begin
      settings <= writeData[`SETTINGS_USED-1:0];
    end
  end

  // trip points hold every written bit for general storage
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lowerTrip <= `LOWER_RESET;
    end else if (writeLower) begin
      lowerTrip <= writeData;
    end
  end

  // upper trip point, same storage as the lower one
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      upperTrip <= `UPPER_RESET;
    end else if (writeUpper) begin
      upperTrip <= writeData;
    end
  end

  // standby level tells the converter to stop after its current result
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      standbyHalt <= 1'b0;
    end else begin
      standbyHalt <= writeSettings ? writeData[`STANDBY_BIT] : settings[`STANDBY_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // conversion results
  // ----------------------------------------------------------------------

  // compare buffer takes every result, even while standby is pending
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      compareBuf <= `READING_RESET;
    end else if (convDone) begin
      compareBuf <= convResult;
    end
  end

  // fault evaluation runs the cycle after the buffer takes a result
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      evalStrobe <= 1'b0;
    end else begin
      evalStrobe <= convDone;
    end
  end

  // visible reading frozen while a bus read runs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reading <= `READING_RESET;
    end else if (convDone && !readActive) begin
      reading <= convResult;
    end
  end

  // ----------------------------------------------------------------------
  // fault evaluation
  // ----------------------------------------------------------------------

  // signed compare of the buffered result against the trip fields
  assign isHot = $signed(compareBuf) > $signed(trip_field(upperTrip));
  assign isCold = $signed(compareBuf) < $signed(trip_field(lowerTrip));

  // fault condition depends on style and on what is being hunted
  always_comb begin
    faulty = isHot;
    if (styleIrq) begin
      unique case (hunt)
        thermal_pkg::HUNT_HOT: faulty = isHot;
        thermal_pkg::HUNT_COLD: faulty = isCold;
      endcase
    end
  end

  assign runDone = faulty && ((faultRun + 3'h1) >= need);

  // alarm sequencing; a read release wins over a conversion event in the same cycle
  always_comb begin
    next_faultRun = faultRun;
    next_alarm = alarm;
    next_hunt = hunt;
    if (releaseReq) begin
      if (alarm) begin
        next_alarm = 1'b0;
        next_hunt = (hunt == thermal_pkg::HUNT_HOT) ?
                    thermal_pkg::HUNT_COLD : thermal_pkg::HUNT_HOT;
        next_faultRun = 3'h0;
      end
    end
    if (evalStrobe) begin
      if (!styleIrq) begin
        next_hunt = thermal_pkg::HUNT_HOT;
        if (alarm) begin
          next_faultRun = 3'h0;
          if (isCold) begin
            next_alarm = 1'b0;
          end
        end else if (runDone) begin
          next_alarm = 1'b1;
          next_faultRun = 3'h0;
        end else begin
          next_faultRun = faulty ? faultRun + 3'h1 : 3'h0;
        end
      end else if (!next_alarm && !alarm) begin
        if (runDone) begin
          next_alarm = 1'b1;
          next_faultRun = 3'h0;
        end else begin
          next_faultRun = faulty ? faultRun + 3'h1 : 3'h0;
        end
      end
    end
  end

  // length of the current run of faulty conversions
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      faultRun <= 3'h0;
    end else begin
      faultRun <= next_faultRun;
    end
  end

  // logical alarm state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alarm <= 1'b0;
    end else begin
      alarm <= next_alarm;
    end
  end

  // which kind of run the interrupt style waits for
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hunt <= thermal_pkg::HUNT_HOT;
    end else begin
      hunt <= next_hunt;
    end
  end

  // ----------------------------------------------------------------------
  // alarm pin
  // ----------------------------------------------------------------------

  // registered copy of the logical alarm
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alarmActive <= 1'b0;
    end else begin
      alarmActive <= next_alarm;
    end
  end

  // open drain: the pin only ever drives low
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alarmPinOut <= 1'b0;
    end else begin
      alarmPinOut <= 1'b0;
    end
  end

  // the pin is pulled low while its level is the driven one
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alarmPinOe <= 1'b0;
    end else begin
      alarmPinOe <= settings[`LEVEL_BIT] ? !next_alarm : next_alarm;
    end
  end

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------

  // nine-bit reading at the top, zeros below
  assign readingWord = {reading, 7'h00};

  // selected register presented to the serial engine
  always_comb begin
    next_readData = readingWord;
    unique case (select)
      `SEL_READING: next_readData = readingWord;
      `SEL_SETTINGS: next_readData = {11'h000, settings};
      `SEL_LOWER: next_readData = lowerTrip;
      `SEL_UPPER: next_readData = upperTrip;
    endcase
  end

  // registered read word
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      readData <= 16'h0000;
    end else begin
      readData <= next_readData;
    end
  end

  // registered copy of the pointer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      selectValue <= `SELECT_RESET;
    end else begin
      selectValue <= select;
    end
  end

endmodule : thermal_sensor_register_file

// File: sim/bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model (
  input wire logic core_clk,
  output logic selectWrite,
  output logic [7:0] selectData,
  output logic regWrite,
  output logic [15:0] writeData,
  output logic readStart,
  output logic readActive
);
  // idle bus at time zero
  initial begin
    {selectWrite, regWrite, readStart, readActive} = '0;
  end
  // pointer byte; the line shows the inverse once released
  task sel(input logic [7:0] d);
    @(posedge core_clk);
    selectWrite <= 1'b1;
    selectData <= d;
    @(posedge core_clk);
    selectWrite <= 1'b0;
    selectData <= ~d;
  endtask : sel
  // data word to the selected register
  task wr(input logic [15:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    writeData <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
    writeData <= ~d;
  endtask : wr
  // read cycle: start pulse inside an active read window
  task rd;
    @(posedge core_clk);
    readStart <= 1'b1;
    readActive <= 1'b1;
    @(posedge core_clk);
    readStart <= 1'b0;
    @(posedge core_clk);
    readActive <= 1'b0;
  endtask : rd
  // long read window held by the caller
  task busy(input logic v);
    @(posedge core_clk);
    readActive <= v;
  endtask : busy
endmodule : bus_master_model

// File: sim/thermal_sensor_register_file_assertions.sv
`timescale 1ns/1ps
module thermal_sensor_register_file_assertions (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic selectWrite,
  input wire logic [7:0] selectData,
  input wire logic regWrite,
  input wire logic [15:0] writeData,
  input wire logic readStart,
  input wire logic readActive,
  input wire logic convDone,
  input wire logic [8:0] convResult,
  input wire logic [15:0] readData,
  input wire logic [1:0] selectValue,
  input wire logic abortOp,
  input wire logic standbyHalt,
  input wire logic alarmActive,
  input wire logic alarmPinOut,
  input wire logic alarmPinOe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_ABORT_SET: assert property (selectWrite && selectData[7:2] != 6'h00 |=> abortOp)
    else $error("abort pulse missing");
  AST_ABORT_QUIET: assert property (!(selectWrite && selectData[7:2] != 6'h00) |=> !abortOp)
    else $error("abort without cause");
  AST_SEL_LOAD: assert property (selectWrite && selectData[7:2] == 6'h00
    |-> ##2 selectValue == $past(selectData[1:0], 2)) else $error("pointer not loaded");
  AST_SEL_HOLD: assert property (!(selectWrite && selectData[7:2] == 6'h00)
    |-> ##2 $stable(selectValue)) else $error("pointer moved");
  AST_READ_LOW: assert property (selectValue == 2'h0 && $past(selectValue) == 2'h0
    |-> readData[6:0] == 7'h00) else $error("reading low bits set");
  AST_CONV_SHOW: assert property (convDone && !readActive && !selectWrite && selectValue == 2'h0
    ##1 !convDone && !selectWrite |=> readData == {$past(convResult, 2), 7'h00})
    else $error("reading not shown");
  AST_CONV_MASK: assert property (convDone && readActive && !selectWrite && selectValue == 2'h0
    ##1 !convDone && !selectWrite |=> $stable(readData)) else $error("masked reading shown");
  AST_STANDBY: assert property (regWrite && selectValue == 2'h1 ##1 !regWrite
    |=> standbyHalt == $past(writeData[0], 2)) else $error("standby not following");
  AST_NO_SPONT: assert property (!convDone [*2] |=> !$rose(alarmActive))
    else $error("alarm without conversion");
endmodule : thermal_sensor_register_file_assertions
bind thermal_sensor_register_file thermal_sensor_register_file_assertions u_chk (
  .core_clk(core_clk), .rst(rst), .selectWrite(selectWrite), .selectData(selectData),
  .regWrite(regWrite), .writeData(writeData), .readStart(readStart), .readActive(readActive),
  .convDone(convDone), .convResult(convResult), .readData(readData), .selectValue(selectValue),
  .abortOp(abortOp), .standbyHalt(standbyHalt), .alarmActive(alarmActive),
  .alarmPinOut(alarmPinOut), .alarmPinOe(alarmPinOe));

// File: sim/test_thermal_sensor_register_file.sv
`timescale 1ns/1ps
`include "thermal_params.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH %0t got %h want %h", $time, a, e); end end
module test_thermal_sensor_register_file;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic convDone = 1'b0;
  logic [8:0] convResult;
  logic selectWrite, regWrite, readStart, readActive, abortOp, standbyHalt;
  logic alarmActive, alarmPinOe, alarmPinOut;
  logic [7:0] selectData;
  logic [15:0] writeData, readData;
  logic [1:0] selectValue;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;
  thermal_sensor_register_file u_dut (.core_clk(core_clk), .rst(rst),
    .selectWrite(selectWrite), .selectData(selectData), .regWrite(regWrite),
    .writeData(writeData), .readStart(readStart), .readActive(readActive),
    .convDone(convDone), .convResult(convResult), .readData(readData),
    .selectValue(selectValue), .abortOp(abortOp), .standbyHalt(standbyHalt),
    .alarmActive(alarmActive), .alarmPinOut(alarmPinOut), .alarmPinOe(alarmPinOe));
  bus_master_model u_mst (.core_clk(core_clk), .selectWrite(selectWrite),
    .selectData(selectData), .regWrite(regWrite), .writeData(writeData),
    .readStart(readStart), .readActive(readActive));
  task settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : settle
  task conv(input logic [8:0] r);
    @(posedge core_clk);
    convDone <= 1'b1;
    convResult <= r;
    @(posedge core_clk);
    convDone <= 1'b0;
    convResult <= ~r;
    settle();
  endtask : conv
  task look(input logic [1:0] p, input logic [15:0] e);
    u_mst.sel({6'h00, p});
    settle();
    `CHK(readData, e)
  endtask : look
  task setw(input logic [7:0] s);
    u_mst.sel(8'h01);
    u_mst.wr({8'h00, s});
    settle();
  endtask : setw
  task t_reset;
    `CHK(selectValue, `SELECT_RESET)
    `CHK(readData, 16'h0000)
    look(`SEL_LOWER, `LOWER_RESET);
    look(`SEL_UPPER, `UPPER_RESET);
    look(`SEL_SETTINGS, 16'h0000);
  endtask : t_reset
  task t_regs;
    u_mst.sel(8'h03);
    u_mst.wr(16'h6000);
    u_mst.rd();
    settle();
    `CHK(readData, 16'h6000)
    u_mst.wr(16'h507F);
    settle();
    `CHK(readData, 16'h507F)
    setw(8'hF8);
    `CHK(readData, 16'h0018)
    u_mst.sel(8'h00);
    u_mst.wr(16'h1234);
    settle();
    `CHK(readData, 16'h0000)
  endtask : t_regs
  task t_abort;
    for (int b = 2; b < 8; b++) begin
      u_mst.sel(8'h02 | (8'h01 << b));
      #1;
      `CHK(abortOp, 1'b1)
      `CHK(selectValue, 2'h0)
    end
  endtask : t_abort
  task t_mask;
    setw(8'h00);
    u_mst.sel(8'h00);
    conv(9'h032);
    `CHK(readData, 16'h1900)
    u_mst.busy(1'b1);
    conv(9'h0B0);
    `CHK(readData, 16'h1900)
    `CHK(alarmActive, 1'b1)
    u_mst.busy(1'b0);
    conv(9'h1CE);
    `CHK(readData, 16'hE700)
    `CHK(alarmActive, 1'b0)
  endtask : t_mask
  task t_comp;
    logic [2:0] need [4];
    need = '{3'h1, 3'h2, 3'h4, 3'h6};
    for (int i = 0; i < 4; i++) begin
      setw({3'h0, i[1:0], i[0], 2'h0});
      for (int k = 1; k < need[i]; k++) conv(9'h0B0);
      `CHK(alarmActive, 1'b0)
      conv(9'h0B0);
      `CHK(alarmPinOe, ~i[0])
      `CHK(alarmPinOut, 1'b0)
      conv(9'h0A0);
      `CHK(alarmActive, 1'b1)
      conv(9'h095);
      `CHK(alarmActive, 1'b0)
    end
  endtask : t_comp
  task t_int;
    setw(8'h02);
    conv(9'h0B0);
    `CHK(alarmActive, 1'b1)
    u_mst.rd();
    conv(9'h0B0);
    `CHK(alarmActive, 1'b0)
    conv(9'h095);
    `CHK(alarmActive, 1'b1)
    setw(8'h03);
    `CHK(alarmActive, 1'b0)
    `CHK(standbyHalt, 1'b1)
  endtask : t_int
  task finish_test;
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  // reset, then each scenario in turn
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    settle();
    t_reset();
    t_regs();
    t_abort();
    t_mask();
    t_comp();
    t_int();
    finish_test();
  end
  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end
endmodule : test_thermal_sensor_register_file
